// [inc/txd_pkg.sv]
package txd_pkg;
    localparam int CFG_RESET_BIT  = 7;
    localparam int CFG_ENABLE_BIT = 6;
    localparam int CFG_WRTYPE_BIT = 5;
    localparam int CFG_CHAN_MSB   = 2;
    localparam int CFG_CHAN_LSB   = 0;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    localparam logic [7:0] CFG_WMASK     = 8'hE7;
    // wishbone byte addresses of the controller's own registers
    localparam logic [3:0] ADDR_CFG    = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_DATA   = 4'h8;
    localparam logic [3:0] ADDR_COUNT  = 4'hC;
    localparam int DATA_W     = 8;
    localparam int NUM_CHAN   = 4;
    localparam int STROBE_LOW = 2;
    localparam int STROBE_GAP = 2;
    typedef enum logic [2:0] {
        DS_IDLE = 3'b001,
        DS_REQ  = 3'b010,
        DS_XFER = 3'b100
    } txd_dev_state_t;
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_ACK  = 4'b0010,
        HS_LOW  = 4'b0100,
        HS_GAP  = 4'b1000
    } txd_host_state_t;
endpackage : txd_pkg

// [inc/txd_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface txd_if;
    import txd_pkg::*;
    logic              reqN;
    logic              ackN;
    logic              wrN;
    logic              rdN;
    logic [DATA_W-1:0] data;
    logic              dataOe;
    modport dev  (output reqN, input ackN, wrN, rdN, data, dataOe);
    modport host (input reqN, output ackN, wrN, rdN, data, dataOe);
endinterface : txd_if
`default_nettype wire

// [verilog/txd_device.sv]
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module txd_device #(
    parameter int MSG_LEN = 4,
    parameter int BUF_DEPTH = 16
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    txd_if.dev                           link,
    input  wire logic [7:0]              cfgWrData,
    input  wire logic                    cfgWrEn,
    output logic      [7:0]              cfgRdData,
    input  wire logic [txd_pkg::NUM_CHAN-1:0] chanDrain,
    output logic      [txd_pkg::NUM_CHAN-1:0] chanWordValid,
    output logic      [txd_pkg::DATA_W-1:0]   chanWord,
    output logic      [txd_pkg::NUM_CHAN-1:0] chanBufFull,
    output logic                         busy
);
    import txd_pkg::*;
    initial begin
        if (MSG_LEN < 1 || MSG_LEN > BUF_DEPTH || BUF_DEPTH > 255)
            $error("txd_device: bad sizes");
    end
    localparam int CW = 8;
    logic [7:0] cfg_q;
    logic rstBitPrev_q;
    logic chanRst_q;
    logic [CW-1:0] level_q [NUM_CHAN];
    logic [CW-1:0] sent_q;
    logic wrPrev_q, rdPrev_q;
    txd_dev_state_t state_q;
    logic reqN_q;
    logic [1:0] owner;
    logic ownerOk, room, strobeEdge;

    always_ff @(posedge clk) begin
        if (reset) cfg_q <= CFG_RESET_VAL;
        else if (cfgWrEn) cfg_q <= cfgWrData & CFG_WMASK;
    end
    assign cfgRdData = cfg_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rstBitPrev_q <= 1'b0;
            chanRst_q    <= 1'b0;
        end else begin
            rstBitPrev_q <= cfg_q[CFG_RESET_BIT];
            chanRst_q    <= cfg_q[CFG_RESET_BIT] & ~rstBitPrev_q;
        end
    end

    assign ownerOk = ~cfg_q[CFG_CHAN_MSB];
    assign owner   = cfg_q[CFG_CHAN_LSB+1:CFG_CHAN_LSB];
    assign room = (CW'(BUF_DEPTH) - level_q[owner]) >= CW'(MSG_LEN);

    // strobe by mode: falling wr, or falling rd while wr is low
    assign strobeEdge = cfg_q[CFG_WRTYPE_BIT] ? (wrPrev_q & ~link.wrN)
                                              : (rdPrev_q & ~link.rdN & ~link.wrN);
    always_ff @(posedge clk) begin
        if (reset) begin
            wrPrev_q <= 1'b1;
            rdPrev_q <= 1'b1;
        end else begin
            wrPrev_q <= link.wrN;
            rdPrev_q <= link.rdN;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || chanRst_q || !cfg_q[CFG_ENABLE_BIT]) begin
            state_q <= DS_IDLE;
            reqN_q  <= 1'b1;
            sent_q  <= '0;
        end else begin
            case (state_q)
                DS_IDLE: begin
                    if (ownerOk && room) begin
                        reqN_q  <= 1'b0;
                        state_q <= DS_REQ;
                    end
                end
                DS_REQ: begin
                    sent_q <= '0;
                    if (!link.ackN) state_q <= DS_XFER;
                end
                DS_XFER: begin
                    if (strobeEdge && !link.ackN) begin
                        sent_q <= sent_q + 1'b1;
                        if (sent_q == CW'(MSG_LEN - 1)) begin
                            reqN_q  <= 1'b1;
                            state_q <= DS_IDLE;
                        end
                    end
                end
                default: state_q <= DS_IDLE;
            endcase
        end
    end
    assign link.reqN = reqN_q;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            logic take;
            assign take = state_q == DS_XFER && strobeEdge && !link.ackN
                          && owner == 2'(g) && ownerOk;
            always_ff @(posedge clk) begin
                if (reset || chanRst_q) begin
                    level_q[g]       <= '0;
                    chanWordValid[g] <= 1'b0;
                    chanBufFull[g]   <= 1'b0;
                end else begin
                    level_q[g] <= level_q[g] + CW'(take) - CW'(chanDrain[g] && level_q[g] != 0);
                    chanWordValid[g] <= take;
                    chanBufFull[g]   <= (level_q[g] + CW'(take)) >= CW'(BUF_DEPTH);
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (reset) chanWord <= '0;
        else if (state_q == DS_XFER && strobeEdge) chanWord <= link.data;
    end
    always_ff @(posedge clk) begin
        if (reset) busy <= 1'b0;
        else busy <= state_q != DS_IDLE;
    end
endmodule : txd_device
`default_nettype wire

// [verilog/txd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module txd_host (
    input  wire logic        clk,
    input  wire logic        reset,
    txd_if.host              link,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o
);
    import txd_pkg::*;
    logic [1:0] mode_q;      // [0] go, [1] wr strobe mode
    logic [DATA_W-1:0] word_q;
    logic [7:0] count_q;
    txd_host_state_t st_q;
    logic [1:0] tmr_q;
    logic ackN_q, wrN_q, rdN_q;
    logic wbHit;
    assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q  <= 2'h0;
            word_q  <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wbHit;
            if (wbHit && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == ADDR_CFG) mode_q <= wb_dat_i[1:0];
                if (wb_adr_i == ADDR_DATA) word_q <= wb_dat_i[DATA_W-1:0];
            end
            if (wbHit) begin
                case (wb_adr_i)
                    ADDR_CFG:    wb_dat_o <= {30'h0, mode_q};
                    ADDR_STATUS: wb_dat_o <= {29'h0, ~link.reqN, ~ackN_q, st_q != HS_IDLE};
                    ADDR_DATA:   wb_dat_o <= {24'h0, word_q};
                    ADDR_COUNT:  wb_dat_o <= {24'h0, count_q};
                    default:     wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= HS_IDLE;
            ackN_q <= 1'b1;
            wrN_q <= 1'b1;
            rdN_q <= 1'b1;
            tmr_q <= 2'h0;
            count_q <= 8'h00;
        end else begin
            case (st_q)
                HS_IDLE: begin
                    ackN_q <= 1'b1;
                    if (mode_q[0] && !link.reqN) st_q <= HS_ACK;
                end
                HS_ACK: begin
                    ackN_q <= 1'b0;
                    wrN_q  <= mode_q[1] ? 1'b1 : 1'b0;
                    st_q   <= HS_GAP;
                    tmr_q  <= 2'(STROBE_GAP - 1);
                end
                HS_LOW: begin
                    if (tmr_q == 2'h0) begin
                        if (mode_q[1]) wrN_q <= 1'b1;
                        else rdN_q <= 1'b1;
                        tmr_q <= 2'(STROBE_GAP - 1);
                        count_q <= count_q + 8'h01;
                        // request withdrawn after this word: free the link at once
                        if (link.reqN) begin
                            ackN_q <= 1'b1;
                            wrN_q  <= 1'b1;
                            st_q   <= HS_IDLE;
                        end else st_q <= HS_GAP;
                    end else tmr_q <= tmr_q - 2'h1;
                end
                HS_GAP: begin
                    if (link.reqN) begin
                        ackN_q <= 1'b1;
                        wrN_q  <= 1'b1;
                        st_q   <= HS_IDLE;
                    end else if (tmr_q == 2'h0) begin
                        if (mode_q[1]) wrN_q <= 1'b0;
                        else rdN_q <= 1'b0;
                        tmr_q <= 2'(STROBE_LOW - 1);
                        st_q <= HS_LOW;
                    end else tmr_q <= tmr_q - 2'h1;
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end
    assign link.ackN   = ackN_q;
    assign link.wrN    = wrN_q;
    assign link.rdN    = rdN_q;
    // host drives data toward the device only
    assign link.data   = word_q + count_q;
    assign link.dataOe = 1'b0;
endmodule : txd_host
`default_nettype wire

// [verification/txd_props.sv]
`timescale 1ns/1ps
`default_nettype none
module txd_props (
    input wire logic                      clk,
    input wire logic                      reset,
    input wire logic                      reqN,
    input wire logic                      ackN,
    input wire logic                      wrN,
    input wire logic                      rdN,
    input wire logic [txd_pkg::DATA_W-1:0] data,
    input wire logic                      dataOe
);
    import txd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_idle_after_rst: assert property (disable iff (1'b0)
        reset |=> reqN && ackN && wrN && rdN) else $error("link not idle after reset");
    a_ack_waits_req: assert property (
        $fell(ackN) |-> !$past(reqN) && !$past(reqN, 2)) else $error("ack without request");
    a_ack_released: assert property (
        $rose(reqN) |-> ##[0:3] ackN) else $error("ack held after request ended");
    a_strobe_width: assert property (
        $fell(rdN) |=> !rdN ##1 rdN) else $error("read strobe width wrong");
    a_strobe_in_ack: assert property (
        $fell(rdN) |-> !ackN && !reqN) else $error("strobe outside handshake");
    a_strobe_gap: assert property (
        $rose(rdN) |=> rdN) else $error("strobe gap too short");
    a_data_steady: assert property (
        $fell(rdN) |=> $stable(data)) else $error("data moved during strobe");
    a_one_way: assert property (
        !dataOe) else $error("data bus not driven by controller");
endmodule : txd_props
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import txd_pkg::*;
    localparam int ML = 4;
    logic        clk = 0, reset = 1, cfgWrEn = 0, we = 0, cyc = 0, ack, busy;
    logic [7:0]  cfgWrData = 0, cfgRdData, chanWord, base;
    logic [3:0]  adr = 0, chanDrain = 0, chanWordValid, chanBufFull;
    logic [31:0] wdat = 0, rdat, rdo;
    int          mismatches = 0, n_checks = 0, tick = 0, cnt = 0, k;
    txd_if bus ();
    txd_device #(.MSG_LEN(ML), .BUF_DEPTH(8)) u_txd_device (.clk(clk), .reset(reset),
        .link(bus), .cfgWrData(cfgWrData), .cfgWrEn(cfgWrEn), .cfgRdData(cfgRdData),
        .chanDrain(chanDrain), .chanWordValid(chanWordValid), .chanWord(chanWord),
        .chanBufFull(chanBufFull), .busy(busy));
    txd_host u_txd_host (.clk(clk), .reset(reset), .link(bus), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_ack_o(ack));
    txd_props u_txd_props (.clk(clk), .reset(reset), .reqN(bus.reqN), .ackN(bus.ackN),
        .wrN(bus.wrN), .rdN(bus.rdN), .data(bus.data), .dataOe(bus.dataOe));
    always #5 clk = ~clk;
    task wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 8000) begin
            mismatches++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        adr <= a; we <= w; wdat <= d; cyc <= 1;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = rdo;
        cyc <= 0;
    endtask : wb
    task cfg(input logic [7:0] v);
        @(posedge clk);
        cfgWrData <= v; cfgWrEn <= 1;
        @(posedge clk);
        cfgWrEn <= 0;
        #1;
    endtask : cfg
    task idle(input int n, input logic [7:0] v);
        cfg(v);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task xfer(input int m, input int ch, input int dr);
        base = 8'($urandom);
        wb(ADDR_DATA, 1, {24'h0, base});
        wb(ADDR_CFG, 1, {30'h0, m[0], 1'b1});
        cfg({2'b01, m[0], 2'b00, ch[2:0]});
        for (int i = 0; i < ML; i++) begin
            k = 0;
            do begin @(posedge clk); #1; k++; end while (chanWordValid === 4'h0 && k < 200);
            chk(chanWordValid, 32'(4'h1 << ch));
            chk(chanWord, 32'(8'(base + cnt + i)));
        end
        cnt += ML;
        cfg(8'h00);
        if (dr) begin
            chanDrain <= 4'(1 << ch);
            repeat (ML) @(posedge clk);
            chanDrain <= 0;
        end
    endtask : xfer
    initial begin
        void'($urandom(47));
        repeat (20) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        #1;
        chk(cfgRdData, CFG_RESET_VAL);
        wb(4'h2, 0, 0);
        chk(rdat, 0);
        cfg(8'hFF);
        chk(cfgRdData, 8'hE7);
        wb(ADDR_CFG, 1, 32'h1);
        idle(40, 8'h44);
        chk(bus.reqN, 1);
        idle(40, 8'h01);
        chk(bus.reqN, 1);
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < NUM_CHAN; c++)
                xfer(m, c, 1);
        xfer(1, 0, 0);
        xfer(1, 0, 0);
        chk(chanBufFull, 4'h1);
        wb(ADDR_CFG, 1, 32'h3);
        idle(40, 8'h60);
        chk(bus.reqN, 1);
        chanDrain <= 4'h1;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (bus.reqN !== 1'b0 && k < 100);
        chanDrain <= 0;
        chk(bus.reqN, 0);
        idle(2, 8'hE0);
        chk(bus.reqN, 1);
        chk(chanBufFull, 4'h0);
        @(posedge clk);
        #1;
        chk(busy, 0);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
